// ==== ethq_params.svh ====
// Purpose: Offsets, bit positions, reset values and timing of the receive queue
// Assumes: 16-bit register port, byte addresses
// Notes:   Definitions only
`ifndef ETHQ_PARAMS_SVH
`define ETHQ_PARAMS_SVH

// Register offsets (byte address)
`define ETHQ_OFF_RXC1     8'h74
`define ETHQ_OFF_RXC2     8'h76
`define ETHQ_OFF_HSTAT    8'h7C
`define ETHQ_OFF_HBC      8'h7E
`define ETHQ_OFF_QCTL     8'h82
`define ETHQ_OFF_DPTR     8'h86
`define ETHQ_OFF_DTT      8'h8C
`define ETHQ_OFF_DBCT     8'h8E
`define ETHQ_OFF_IER      8'h90
`define ETHQ_OFF_ISR      8'h92
`define ETHQ_OFF_FCTR     8'h9C
`define ETHQ_OFF_DATA     8'hC0

// Field positions
`define ETHQ_RXC1_EN      0
`define ETHQ_RXC1_FLOW    10
`define ETHQ_RXC2_CSUM    0
`define ETHQ_QC_DMA       3
`define ETHQ_QC_ADQ       4
`define ETHQ_QC_FEN       5
`define ETHQ_QC_BEN       6
`define ETHQ_QC_TEN       7
`define ETHQ_QC_OFS       9
`define ETHQ_QC_FST       10
`define ETHQ_DP_AINC      14
`define ETHQ_IS_RX        13

// Frame layout in words: status, byte count, data
`define ETHQ_HDR_STAT     0
`define ETHQ_HDR_BC       1
`define ETHQ_HDR_DATA     2
`define ETHQ_MAX_BYTES    2000

// Reset value of every register
`define ETHQ_RST_REG      16'h0000

// Timing
`define ETHQ_US_NS        1000
`define ETHQ_CLK_NS       40

`endif

// ==== ethq_fifo.sv ====
// Purpose: Ingress FIFO between the MAC stream and the queue writer
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Flip-flop storage, registered ready toward the source
`timescale 1ns/1ps

module ethq_fifo #(
  parameter int WIDTH = 45,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_s_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
    logic                        rdy;
  } ethq_fifo_st_t;

  ethq_fifo_st_t s_q, s_d;
  logic          push, pop;

  assign out_valid = (s_q.cnt != '0);
  assign out_data  = s_q.mem[s_q.rp];
  assign in_ready  = s_q.rdy;
  assign push      = in_valid && s_q.rdy;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.rdy = (s_d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_fifo_bound;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.cnt == (AW+1)'(DEPTH)) |-> !s_q.rdy ##1 (s_q.cnt <= (AW+1)'(DEPTH));
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo overfilled");
endmodule : ethq_fifo

// ==== ethq_tick.sv ====
// Purpose: One-cycle pulse every microsecond for the residence timer
// Assumes: Clock period divides the microsecond evenly
// Notes:   Rounded down so that no interval exceeds the unit
`timescale 1ns/1ps
`include "ethq_params.svh"

module ethq_tick #(
  parameter int CLK_NS = `ETHQ_CLK_NS,
  parameter int US_NS  = `ETHQ_US_NS
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_s_n,
  // Microsecond strobe
  output logic      tick_q
);
  localparam int CYC = (US_NS / CLK_NS < 1) ? 1 : US_NS / CLK_NS;
  localparam int CW  = (CYC > 1) ? $clog2(CYC) : 1;

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } ethq_tick_st_t;

  ethq_tick_st_t s_q, s_d;

  assign tick_q = s_q.tick;

  always_comb begin
    s_d = s_q;
    s_d.tick = (s_q.cnt == CW'(CYC - 1));
    s_d.cnt  = s_d.tick ? '0 : s_q.cnt + CW'(1);
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_tick_gap;
    @(posedge clk_sys) disable iff (!rst_s_n)
    $rose(s_q.tick) |=> !s_q.tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick longer than one cycle");
endmodule : ethq_tick

// ==== ethq_rx_queue.sv ====
// Purpose: Host-side receive queue with frame headers, DMA reads and thresholds
// Assumes: Register port and MAC stream are synchronous to clk_sys
// Notes:   Queue depth is a power of two in 16-bit words
`timescale 1ns/1ps
`include "ethq_params.svh"

package ethq_pkg;
  typedef enum logic [1:0] {
    W_IDLE,
    W_DATA,
    W_DROP
  } ethq_wst_t;
endpackage : ethq_pkg

module ethq_rx_queue #(
  parameter int QWORDS = 2048,
  parameter int FDEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic        bus_rd,
  input  wire logic        bus_wr,
  input  wire logic [7:0]  bus_addr,
  input  wire logic [1:0]  bus_be,
  input  wire logic [15:0] bus_wdata,
  output logic [15:0]      bus_rdata_q,
  output logic             bus_rvalid_q,
  // Frame stream from the MAC
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [15:0] rx_data,
  input  wire logic        rx_last,
  input  wire logic [15:0] rx_status,
  input  wire logic [11:0] rx_len,
  // Controls and interrupt
  output logic             irq_q,
  output logic             rx_flow_en_q,
  output logic [3:0]       rx_csum_en_q
);
  localparam int AW   = $clog2(QWORDS);
  localparam int FW   = 45;
  localparam int MAXB = `ETHQ_MAX_BYTES;
  localparam logic [AW:0] NEED = (AW+1)'(MAXB / 2 + 4);

  typedef struct packed {
    ethq_pkg::ethq_wst_t       wst;
    logic [15:0]               rxc1;
    logic [15:0]               rxc2;
    logic [15:0]               qctl;
    logic [15:0]               dptr;
    logic [15:0]               dtt;
    logic [15:0]               dbct;
    logic [15:0]               interrupt_enable;
    logic [15:0]               interrupt_status;
    logic [7:0]                fthr;
    logic [7:0]                fcnt;
    logic [15:0]               hstat;
    logic [15:0]               hbc;
    logic [AW-1:0]             head;
    logic [AW-1:0]             rd_base;
    logic [AW-1:0]             wr_ptr;
    logic [AW-1:0]             fr_base;
    logic [11:0]               wr_cnt;
    logic [7:0]                frames;
    logic [15:0]               bytes;
    logic [15:0]               dur;
    logic                      dummy;
    logic [15:0]               rdata;
    logic                      rvalid;
    logic                      irq;
    logic                      flow;
    logic [3:0]                csum;
    logic [QWORDS-1:0][15:0]   mem;
  } ethq_st_t;

  ethq_st_t        s_q, s_d;
  logic [1:0]      rsync_q;
  logic            rst_s_n;
  logic            tick;
  logic            f_valid, f_ready;
  logic [FW-1:0]   f_word;
  logic [AW-1:0]   used;
  logic [2:0]      tstat;
  logic [15:0]     wv, clr, bc;
  logic [AW-1:0]   didx;

  function automatic logic [15:0] ethq_wmask(input logic [15:0] o, input logic [15:0] n,
                                             input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction : ethq_wmask

  // Start of the frame that follows the one at b, kept on double-word boundaries
  function automatic logic [AW-1:0] ethq_next(input logic [AW-1:0] b, input logic [15:0] c);
    logic [11:0] dw;
    dw = 12'((c[11:0] + 12'd3) >> 2);
    return b + AW'(`ETHQ_HDR_DATA) + AW'({dw, 1'b0});
  endfunction : ethq_next

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rsync_q <= 2'b00;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_s_n = rsync_q[1];

  ethq_tick u_tick (
    .clk_sys (clk_sys),
    .rst_s_n (rst_s_n),
    .tick_q  (tick)
  );

  ethq_fifo #(.WIDTH(FW), .DEPTH(FDEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_s_n   (rst_s_n),
    .in_valid  (rx_valid),
    .in_ready  (rx_ready),
    .in_data   ({rx_last, rx_len, rx_status, rx_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_word)
  );

  assign f_ready      = (s_q.wst == ethq_pkg::W_DATA) || (s_q.wst == ethq_pkg::W_DROP);
  assign used         = s_q.wr_ptr - s_q.rd_base;
  assign bus_rdata_q  = s_q.rdata;
  assign bus_rvalid_q = s_q.rvalid;
  assign irq_q        = s_q.irq;
  assign rx_flow_en_q = s_q.flow;
  assign rx_csum_en_q = s_q.csum;

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.rdata  = s_q.rdata;
    wv   = ethq_wmask(16'h0000, bus_wdata, bus_be);
    clr  = 16'h0000;
    bc   = 16'h0000;
    didx = s_q.rd_base + AW'(`ETHQ_HDR_DATA) + AW'(s_q.dptr[10:1]);

    // Residence of the oldest frame, in microseconds
    if (s_q.frames == 8'h00) begin
      s_d.dur = 16'h0000;
    end else if (tick && s_q.dur != 16'hFFFF) begin
      s_d.dur = s_q.dur + 16'h0001;
    end

    // Queue writer
    case (s_q.wst)
      ethq_pkg::W_IDLE: begin
        if (f_valid) begin
          if (!s_q.rxc1[`ETHQ_RXC1_EN]) begin
            s_d.wst = ethq_pkg::W_DROP;
          end else if ({1'b0, used} + NEED <= (AW+1)'(QWORDS)) begin
            s_d.fr_base = s_q.wr_ptr;
            s_d.wr_ptr  = s_q.wr_ptr + AW'(`ETHQ_HDR_DATA);
            s_d.wr_cnt  = 12'h000;
            if (s_q.qctl[`ETHQ_QC_OFS]) begin
              s_d.mem[s_d.wr_ptr] = 16'h0000;
              s_d.wr_ptr = s_d.wr_ptr + AW'(1);
            end
            s_d.wst = ethq_pkg::W_DATA;
          end
        end
      end
      ethq_pkg::W_DATA: begin
        if (f_valid) begin
          if (s_q.wr_cnt < 12'(MAXB)) begin
            s_d.mem[s_q.wr_ptr] = f_word[15:0];
            s_d.wr_ptr = s_q.wr_ptr + AW'(1);
            s_d.wr_cnt = s_q.wr_cnt + 12'd2;
          end
          if (f_word[44]) begin
            bc = (f_word[43:32] > 12'(MAXB)) ? 16'(MAXB) : {4'h0, f_word[43:32]};
            if (s_q.qctl[`ETHQ_QC_OFS]) begin
              bc = bc + 16'h0002;
            end
            s_d.mem[s_q.fr_base + AW'(`ETHQ_HDR_STAT)] = f_word[31:16];
            s_d.mem[s_q.fr_base + AW'(`ETHQ_HDR_BC)]   = bc;
            s_d.wr_ptr = ethq_next(s_q.fr_base, bc);
            s_d.frames = s_d.frames + 8'h01;
            s_d.bytes  = s_d.bytes + bc;
            s_d.wst    = ethq_pkg::W_IDLE;
          end
        end
      end
      ethq_pkg::W_DROP: begin
        if (f_valid && f_word[44]) begin
          s_d.wst = ethq_pkg::W_IDLE;
        end
      end
      default: begin
        s_d.wst = ethq_pkg::W_IDLE;
      end
    endcase

    // Register writes
    if (bus_wr) begin
      case (bus_addr)
        `ETHQ_OFF_RXC1: s_d.rxc1 = ethq_wmask(s_q.rxc1, bus_wdata, bus_be);
        `ETHQ_OFF_RXC2: s_d.rxc2 = ethq_wmask(s_q.rxc2, bus_wdata, bus_be);
        `ETHQ_OFF_DPTR: s_d.dptr = ethq_wmask(s_q.dptr, bus_wdata, bus_be);
        `ETHQ_OFF_DTT:  s_d.dtt  = ethq_wmask(s_q.dtt, bus_wdata, bus_be);
        `ETHQ_OFF_DBCT: s_d.dbct = ethq_wmask(s_q.dbct, bus_wdata, bus_be);
        `ETHQ_OFF_IER:  s_d.interrupt_enable  = ethq_wmask(s_q.interrupt_enable, bus_wdata, bus_be);
        `ETHQ_OFF_FCTR: s_d.fthr = bus_be[0] ? bus_wdata[7:0] : s_q.fthr;
        `ETHQ_OFF_ISR: begin
          clr = wv;
          s_d.interrupt_status = s_q.interrupt_status & ~clr;
          if (clr[`ETHQ_IS_RX] && s_q.interrupt_status[`ETHQ_IS_RX]) begin
            s_d.fcnt = s_d.frames;
          end
        end
        `ETHQ_OFF_QCTL: begin
          s_d.qctl = ethq_wmask(s_q.qctl, bus_wdata, bus_be);
          s_d.qctl[12:10] = s_q.qctl[12:10];
          if (s_d.qctl[`ETHQ_QC_DMA] && !s_q.qctl[`ETHQ_QC_DMA]) begin
            s_d.dummy = 1'b1;
          end
          if (!s_d.qctl[`ETHQ_QC_DMA] && s_q.qctl[`ETHQ_QC_DMA] &&
              s_q.qctl[`ETHQ_QC_ADQ] && s_q.frames != 8'h00) begin
            bc = s_q.mem[s_q.rd_base + AW'(`ETHQ_HDR_BC)];
            s_d.rd_base = ethq_next(s_q.rd_base, bc);
            s_d.frames  = s_d.frames - 8'h01;
            s_d.bytes   = s_d.bytes - bc;
            s_d.dur     = 16'h0000;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped offsets answer zero
    if (bus_rd) begin
      s_d.rvalid = 1'b1;
      case (bus_addr)
        `ETHQ_OFF_RXC1:  s_d.rdata = s_q.rxc1;
        `ETHQ_OFF_RXC2:  s_d.rdata = s_q.rxc2;
        `ETHQ_OFF_HSTAT: s_d.rdata = s_q.hstat;
        `ETHQ_OFF_QCTL:  s_d.rdata = s_q.qctl;
        `ETHQ_OFF_DPTR:  s_d.rdata = s_q.dptr;
        `ETHQ_OFF_DTT:   s_d.rdata = s_q.dtt;
        `ETHQ_OFF_DBCT:  s_d.rdata = s_q.dbct;
        `ETHQ_OFF_IER:   s_d.rdata = s_q.interrupt_enable;
        `ETHQ_OFF_ISR:   s_d.rdata = s_q.interrupt_status;
        `ETHQ_OFF_HBC: begin
          s_d.rdata = {4'h0, s_q.hbc[11:0]};
          s_d.hstat = s_q.mem[s_q.head + AW'(`ETHQ_HDR_STAT)];
          s_d.hbc   = s_q.mem[s_q.head + AW'(`ETHQ_HDR_BC)];
          s_d.head  = ethq_next(s_q.head, s_d.hbc);
        end
        `ETHQ_OFF_FCTR: begin
          s_d.rdata = {s_q.fcnt, s_q.fthr};
          s_d.hstat = s_q.mem[s_q.rd_base + AW'(`ETHQ_HDR_STAT)];
          s_d.hbc   = s_q.mem[s_q.rd_base + AW'(`ETHQ_HDR_BC)];
          s_d.head  = ethq_next(s_q.rd_base, s_d.hbc);
        end
        `ETHQ_OFF_DATA: begin
          if (!s_q.qctl[`ETHQ_QC_DMA]) begin
            s_d.rdata = 16'h0000;
          end else if (s_q.dummy) begin
            s_d.rdata = 16'h0000;
            s_d.dummy = 1'b0;
          end else begin
            s_d.rdata = s_q.mem[didx];
            if (s_q.dptr[`ETHQ_DP_AINC]) begin
              s_d.dptr[10:0] = s_q.dptr[10:0] + 11'd2;
            end
          end
        end
        default: s_d.rdata = 16'h0000;
      endcase
    end

    // Thresholds; a new event wins over a clear in the same cycle
    tstat = {s_q.qctl[`ETHQ_QC_TEN] && (s_q.dur > s_q.dtt),
             s_q.qctl[`ETHQ_QC_BEN] && (s_q.bytes > s_q.dbct),
             s_q.qctl[`ETHQ_QC_FEN] && (s_q.frames > s_q.fthr)};
    s_d.qctl[12:10] = tstat;
    if ((tstat & ~s_q.qctl[12:10]) != 3'b000) begin
      s_d.interrupt_status[`ETHQ_IS_RX] = 1'b1;
      s_d.fcnt = s_d.frames;
    end

    s_d.irq  = s_q.interrupt_status[`ETHQ_IS_RX] && s_q.interrupt_enable[`ETHQ_IS_RX];
    s_d.flow = s_q.rxc1[`ETHQ_RXC1_FLOW];
    s_d.csum = s_q.rxc2[`ETHQ_RXC2_CSUM +: 4];
  end

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  property p_hdr;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.wst == ethq_pkg::W_DATA && f_valid && f_word[44])
      |=> (s_q.mem[$past(s_q.fr_base)] == $past(f_word[31:16])) && (s_q.wst == ethq_pkg::W_IDLE);
  endproperty
  a_hdr: assert property (p_hdr) else $error("status word not at frame start");

  property p_max;
    @(posedge clk_sys) disable iff (!rst_s_n)
    s_q.wr_cnt <= 12'(MAXB);
  endproperty
  a_max: assert property (p_max) else $error("frame data over limit");

  property p_en;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.wst == ethq_pkg::W_IDLE && !s_q.rxc1[`ETHQ_RXC1_EN] && f_valid) |=> s_q.wst == ethq_pkg::W_DROP;
  endproperty
  a_en: assert property (p_en) else $error("frame taken while receive disabled");

  property p_ofs;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.wst == ethq_pkg::W_IDLE && s_q.qctl[`ETHQ_QC_OFS]
      && s_q.rxc1[`ETHQ_RXC1_EN] && f_valid && ({1'b0, used} + NEED <= (AW+1)'(QWORDS)))
      |=> s_q.wr_ptr == $past(s_q.wr_ptr) + AW'(3);
  endproperty
  a_ofs: assert property (p_ofs) else $error("two-byte offset missing");

  property p_dummy;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (bus_rd && bus_addr == `ETHQ_OFF_DATA && s_q.qctl[`ETHQ_QC_DMA] && s_q.dummy)
      |=> bus_rvalid_q && bus_rdata_q == 16'h0000 && !s_q.dummy;
  endproperty
  a_dummy: assert property (p_dummy) else $error("first DMA read not dummy");

  property p_inc;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (bus_rd && bus_addr == `ETHQ_OFF_DATA && s_q.qctl[`ETHQ_QC_DMA] && !s_q.dummy
      && s_q.dptr[`ETHQ_DP_AINC] && !bus_wr)
      |=> s_q.dptr[10:0] == $past(s_q.dptr[10:0]) + 11'd2;
  endproperty
  a_inc: assert property (p_inc) else $error("data pointer did not advance");

  property p_fthr;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.qctl[`ETHQ_QC_FEN] && s_q.frames > s_q.fthr && !s_q.qctl[`ETHQ_QC_FST])
      |=> s_q.qctl[`ETHQ_QC_FST] && s_q.interrupt_status[`ETHQ_IS_RX] ##1 s_q.irq == $past(s_q.interrupt_enable[`ETHQ_IS_RX]);
  endproperty
  a_fthr: assert property (p_fthr) else $error("frame threshold missed");

  property p_bthr;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.qctl[`ETHQ_QC_BEN] && s_q.bytes > s_q.dbct) |=> s_q.qctl[`ETHQ_QC_FST + 1];
  endproperty
  a_bthr: assert property (p_bthr) else $error("byte threshold missed");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (s_q.interrupt_status[`ETHQ_IS_RX] && s_q.interrupt_enable[`ETHQ_IS_RX]) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_w1c;
    @(posedge clk_sys) disable iff (!rst_s_n)
    (bus_wr && bus_addr == `ETHQ_OFF_ISR && bus_be == 2'b11 && bus_wdata == 16'hFFFF
      && s_q.interrupt_status[`ETHQ_IS_RX] && (tstat & ~s_q.qctl[12:10]) == 3'b000)
      |=> !s_q.interrupt_status[`ETHQ_IS_RX] && s_q.fcnt == $past(s_d.frames);
  endproperty
  a_w1c: assert property (p_w1c) else $error("interrupt clear failed");
endmodule : ethq_rx_queue

// ==== ethq_mac_model.sv ====
// Purpose: Frame source standing in for the MAC on the receive stream
// Assumes: One frame of NW words per start pulse, words counted up from 16'h1100
// Notes:   Data lines show the inverse of the last word once a frame ends
`timescale 1ns/1ps

module ethq_mac_model #(
  parameter int NW = 4
) (
  // Clock and control
  input  wire logic        clk_sys,
  input  wire logic        start,
  input  wire logic [15:0] status,
  input  wire logic [11:0] len,
  output logic             done,
  // Stream toward the queue
  output logic             rx_valid,
  input  wire logic        rx_ready,
  output logic [15:0]      rx_data,
  output logic             rx_last,
  output logic [15:0]      rx_status,
  output logic [11:0]      rx_len
);
  int idx;

  initial begin
    {rx_valid, rx_last, done, rx_data, rx_status, rx_len} = '0;
    idx = 0;
  end

  always @(posedge clk_sys) begin
    if (rx_valid && rx_ready) begin
      if (rx_last) begin
        rx_valid <= 1'b0;
        rx_last  <= 1'b0;
        rx_data  <= ~rx_data;
        done     <= 1'b1;
      end else begin
        idx     <= idx + 1;
        rx_data <= 16'h1100 + 16'(idx + 1);
        rx_last <= (idx + 2 == NW);
      end
    end else if (start && !rx_valid) begin
      idx       <= 0;
      rx_valid  <= 1'b1;
      rx_data   <= 16'h1100;
      rx_last   <= (NW == 1);
      rx_status <= status;
      rx_len    <= len;
      done      <= 1'b0;
    end
  end
endmodule : ethq_mac_model

// ==== ethq_rx_queue_bench.sv ====
// Purpose: Register-level test of the receive queue with a MAC frame source
// Assumes: Host bus synchronous to clk_sys, one request per two cycles
// Notes:   Writer latency after the last word is not fixed, so a margin is waited
`timescale 1ns/1ps
`include "ethq_params.svh"

module ethq_rx_queue_bench;
  logic        clk_sys, rst_n, bus_rd, bus_wr, bus_rvalid_q, start, done;
  logic        rx_valid, rx_ready, rx_last, irq_q, rx_flow_en_q;
  logic [1:0]  bus_be;
  logic [3:0]  rx_csum_en_q;
  logic [7:0]  bus_addr;
  logic [11:0] rx_len;
  logic [15:0] bus_wdata, bus_rdata_q, rx_data, rx_status, stat;
  int          mismatches, checked;
  logic [7:0]  offs [12] = '{8'h00, `ETHQ_OFF_RXC1, `ETHQ_OFF_RXC2, `ETHQ_OFF_HSTAT, `ETHQ_OFF_HBC,
                             `ETHQ_OFF_QCTL, `ETHQ_OFF_DPTR, `ETHQ_OFF_DTT, `ETHQ_OFF_DBCT,
                             `ETHQ_OFF_IER, `ETHQ_OFF_ISR, `ETHQ_OFF_DATA};

  ethq_rx_queue u_ethq_rx_queue (.clk_sys(clk_sys), .rst_n(rst_n), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .bus_rvalid_q(bus_rvalid_q), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .rx_last(rx_last), .rx_status(rx_status), .rx_len(rx_len), .irq_q(irq_q),
    .rx_flow_en_q(rx_flow_en_q), .rx_csum_en_q(rx_csum_en_q));

  ethq_mac_model u_ethq_mac_model (.clk_sys(clk_sys), .start(start), .status(stat), .len(12'h008),
    .done(done), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .rx_status(rx_status), .rx_len(rx_len));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic test_done;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clk_sys);
    bus_wr    <= 1'b0;
  endtask : wr

  // Answer is registered at the taking edge and stands for one cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clk_sys);
    bus_rd   <= 1'b0;
    #1;
    chk({15'h0000, bus_rvalid_q}, 16'h0001);
    chk(bus_rdata_q, exp);
  endtask : rd

  task automatic send(input logic [15:0] st);
    @(posedge clk_sys);
    start <= 1'b1;
    stat  <= st;
    @(posedge clk_sys);
    start <= 1'b0;
    #1;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(posedge clk_sys) #1;
    repeat (30) @(posedge clk_sys);
  endtask : send

  initial begin
    {rst_n, bus_rd, bus_wr, bus_addr, bus_wdata, start, stat} = '0;
    bus_be = 2'b11;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, rx_ready}, 16'h0001);
    foreach (offs[i]) rd(offs[i], `ETHQ_RST_REG);
    wr(`ETHQ_OFF_HSTAT, 16'hFFFF);
    rd(`ETHQ_OFF_HSTAT, 16'h0000);
    wr(`ETHQ_OFF_RXC1, 16'h0400);
    rd(`ETHQ_OFF_RXC1, 16'h0400);
    chk({15'h0000, rx_flow_en_q}, 16'h0001);
    wr(`ETHQ_OFF_RXC2, 16'h000F);
    rd(`ETHQ_OFF_RXC2, 16'h000F);
    chk({12'h000, rx_csum_en_q}, 16'h000F);
    wr(`ETHQ_OFF_DTT, 16'h0001);
    wr(`ETHQ_OFF_DBCT, 16'h0007);
    wr(`ETHQ_OFF_QCTL, 16'h00E0);
    // Receive disabled: the frame must be dropped
    send(16'h8001);
    rd(`ETHQ_OFF_QCTL, 16'h00E0);
    wr(`ETHQ_OFF_RXC1, 16'h0401);
    send(16'h8001);
    repeat (60) @(posedge clk_sys);
    rd(`ETHQ_OFF_QCTL, 16'h1CE0);
    rd(`ETHQ_OFF_ISR, 16'h2000);
    chk({15'h0000, irq_q}, 16'h0000);
    wr(`ETHQ_OFF_IER, 16'h2000);
    rd(`ETHQ_OFF_IER, 16'h2000);
    chk({15'h0000, irq_q}, 16'h0001);
    wr(`ETHQ_OFF_ISR, 16'hFFFF);
    rd(`ETHQ_OFF_ISR, 16'h0000);
    chk({15'h0000, irq_q}, 16'h0000);
    rd(`ETHQ_OFF_FCTR, 16'h0100);
    rd(`ETHQ_OFF_HSTAT, 16'h8001);
    // A big-endian host sees the status word with its bytes exchanged
    chk({bus_rdata_q[7:0], bus_rdata_q[15:8]}, 16'h0180);
    rd(`ETHQ_OFF_HBC, 16'h0008);
    wr(`ETHQ_OFF_DPTR, 16'h4000);
    wr(`ETHQ_OFF_QCTL, 16'h00F8);
    rd(`ETHQ_OFF_DATA, 16'h0000);
    for (int i = 0; i < 4; i++) rd(`ETHQ_OFF_DATA, 16'h1100 + 16'(i));
    wr(`ETHQ_OFF_QCTL, 16'h00F0);
    repeat (4) @(posedge clk_sys);
    rd(`ETHQ_OFF_QCTL, 16'h00F0);
    // Two-byte offset: count grows by two, a pad word leads the data
    wr(`ETHQ_OFF_QCTL, 16'h02F0);
    send(16'h8002);
    rd(`ETHQ_OFF_FCTR, 16'h0100);
    rd(`ETHQ_OFF_HSTAT, 16'h8002);
    rd(`ETHQ_OFF_HBC, 16'h000A);
    wr(`ETHQ_OFF_DPTR, 16'h4000);
    wr(`ETHQ_OFF_QCTL, 16'h02F8);
    rd(`ETHQ_OFF_DATA, 16'h0000);
    rd(`ETHQ_OFF_DATA, 16'h0000);
    for (int i = 0; i < 4; i++) rd(`ETHQ_OFF_DATA, 16'h1100 + 16'(i));
    rd(`ETHQ_OFF_DATA, 16'h0000);
    wr(`ETHQ_OFF_QCTL, 16'h02F0);
    repeat (4) @(posedge clk_sys);
    rd(`ETHQ_OFF_QCTL, 16'h02F0);
    // Low byte enable only; the frame count byte ignores writes
    @(posedge clk_sys);
    bus_be <= 2'b01;
    wr(`ETHQ_OFF_DBCT, 16'hABCD);
    rd(`ETHQ_OFF_DBCT, 16'h00CD);
    wr(`ETHQ_OFF_FCTR, 16'hFF05);
    rd(`ETHQ_OFF_FCTR, 16'h0105);
    test_done();
  end

  initial begin
    #(40 * 20000);
    mismatches++;
    test_done();
  end
endmodule : ethq_rx_queue_bench
